// >>> verilog/ofhd_regs.sv
/*
  Output format, static hold and disable register bank, with glitch-free
  per-output hold gating. Assumes a serial port decoder presents byte writes
  and reads at ref_clk_i, and that clk_out_i carries each output's divided
  clock, asynchronous to ref_clk_i.
*/
`timescale 1ns/1ps
// Overview of operation
// - Output five format code: disable, CMOS, LVDS variants, LVPECL, CML.
// - Reference select picks external pins or clock inputs one to four.
// - Hold code: normal, static low, static high; code three reserved.
// - Entering or leaving hold never glitches or truncates an output pulse.
// - Hold fields of outputs four..one sit at 7:6, 5:4, 3:2, 1:0.
// - Averaging field in bits 7:3 sets holdover multiplier averaging time.
// - Averaging register resets to 1100 0000.
// - Bit five set disables output five buffer and its divider.
// - Bits three..zero disable outputs four..one and their dividers.
// - Reserved bits of format and disable registers are read-only.
// - Sleep disables every clock output regardless of format settings.
module ofhd_regs #(
  parameter int unsigned NOUT = ofhd_pkg::NUM_OUT
) (
  input wire logic ref_clk_i,
  input wire logic rstn_i,
  input wire logic wr_en_i,
  input wire logic rd_en_i,
  input wire logic [7:0] addr_i,
  input wire logic [7:0] wdata_i,
  input wire logic sleep_i,
  input wire logic [NOUT-1:0] clk_out_i,
  output logic [7:0] rdata_o,
  output logic [2:0] out5_signal_format_o,
  output logic [2:0] freq_offset_ref_select_o,
  output logic [4:0] holdover_average_time_o,
  output logic [NOUT-1:0] output_disable_o,
  output logic [NOUT-1:0] out_held_o,
  output logic [NOUT-1:0] held_level_o
);
  // ****************************************************
  // State
  // ****************************************************
  typedef struct packed {
    logic [7:0] fmt_ref;
    logic [7:0] hold_14;
    logic [7:0] avg_h5;
    logic [7:0] dis;
    logic [7:0] rdata;
    logic [NOUT-1:0] sync1;
    logic [NOUT-1:0] sync2;
    logic [NOUT-1:0] pdown;
    ofhd_pkg::ofhd_hold_st_t [NOUT-1:0] hst;
    logic [NOUT-1:0] held;
    logic [NOUT-1:0] lvl;
  } ofhd_state_t;

  ofhd_state_t s_q;
  ofhd_state_t s_d;
  logic [NOUT-1:0][1:0] hold_code;

  // Gather the five hold fields; output five lives in the averaging register
  for (genvar g = 0; g < NOUT - 1; g++) begin : g_hold
    assign hold_code[g] =
      s_q.hold_14[g*ofhd_pkg::HOLD_W +: ofhd_pkg::HOLD_W];
  end
  assign hold_code[NOUT-1] =
    s_q.avg_h5[ofhd_pkg::H5_LSB +: ofhd_pkg::HOLD_W];

  // ****************************************************
  // Next state
  // ****************************************************
  // Holds only start or end when the output already sits at the target
  // level, so the hand-over never cuts a pulse short.
  always_comb begin
    logic [1:0] code;
    logic [NOUT-1:0] dis_vec;
    logic flip;
    logic at_lvl;
    code = ofhd_pkg::HOLD_NORMAL;
    dis_vec = '0;
    flip = 1'b0;
    at_lvl = 1'b0;
    s_d = s_q;
    s_d.sync1 = clk_out_i;
    s_d.sync2 = s_q.sync1;
    if (wr_en_i) begin
      unique case (addr_i)
        ofhd_pkg::ADDR_FMT_REF: begin
          s_d.fmt_ref = wdata_i & ofhd_pkg::WMASK_FMT_REF;
        end
        ofhd_pkg::ADDR_HOLD_14: begin
          s_d.hold_14 = wdata_i & ofhd_pkg::WMASK_HOLD_14;
        end
        ofhd_pkg::ADDR_AVG_H5: begin
          s_d.avg_h5 = wdata_i & ofhd_pkg::WMASK_AVG_H5;
        end
        ofhd_pkg::ADDR_DISABLE: begin
          s_d.dis = wdata_i & ofhd_pkg::WMASK_DISABLE;
        end
        default: s_d.fmt_ref = s_q.fmt_ref; // Unmapped writes ignored
      endcase
    end
    if (rd_en_i) begin
      unique case (addr_i)
        ofhd_pkg::ADDR_FMT_REF: s_d.rdata = s_q.fmt_ref;
        ofhd_pkg::ADDR_HOLD_14: s_d.rdata = s_q.hold_14;
        ofhd_pkg::ADDR_AVG_H5: s_d.rdata = s_q.avg_h5;
        ofhd_pkg::ADDR_DISABLE: s_d.rdata = s_q.dis;
        default: s_d.rdata = 8'h00;
      endcase
    end
    // Per-output power-down: own bit, output five format, or sleep
    dis_vec[3:0] = s_q.dis[3:0];
    dis_vec[4] = s_q.dis[ofhd_pkg::DIS5_BIT]
      | (s_q.fmt_ref[ofhd_pkg::FMT_LSB +: 3]
      == ofhd_pkg::FMT_DISABLE);
    s_d.pdown = dis_vec | {NOUT{sleep_i}};
    for (int i = 0; i < NOUT; i++) begin
      code = hold_code[i];
      at_lvl = (s_q.sync2[i] == s_q.lvl[i]);
      // A hold code naming the other level than the one stored
      flip = (code == ofhd_pkg::HOLD_LOW && s_q.lvl[i])
        || (code == ofhd_pkg::HOLD_HIGH && !s_q.lvl[i]);
      unique case (s_q.hst[i])
        ofhd_pkg::OFHD_RUN: begin
          if (code == ofhd_pkg::HOLD_LOW || code == ofhd_pkg::HOLD_HIGH) begin
            s_d.lvl[i] = (code == ofhd_pkg::HOLD_HIGH);
            s_d.hst[i] = ofhd_pkg::OFHD_WAIT_LVL;
          end
        end
        ofhd_pkg::OFHD_WAIT_LVL: begin
          if (code == ofhd_pkg::HOLD_NORMAL) begin
            s_d.hst[i] = ofhd_pkg::OFHD_RUN;
          end else if (flip) begin
            // Level swapped before the hold took: chase the new level
            s_d.lvl[i] = ~s_q.lvl[i];
          end else if (at_lvl) begin
            s_d.held[i] = 1'b1;
            s_d.hst[i] = ofhd_pkg::OFHD_HELD;
          end
        end
        ofhd_pkg::OFHD_HELD: begin
          // Release only while the live clock matches the held level; a
          // swap to the other level runs free until that level comes round
          if ((code == ofhd_pkg::HOLD_NORMAL || flip) && at_lvl) begin
            s_d.held[i] = 1'b0;
            s_d.hst[i] = ofhd_pkg::OFHD_RUN;
          end
        end
        default: s_d.hst[i] = ofhd_pkg::OFHD_RUN;
      endcase
    end
  end

  // ****************************************************
  // Registers
  // ****************************************************
  // Synchronous reset to documented values
  always_ff @(posedge ref_clk_i) begin
    if (!rstn_i) begin
      s_q <= '0;
      s_q.fmt_ref <= ofhd_pkg::RST_FMT_REF;
      s_q.hold_14 <= ofhd_pkg::RST_HOLD_14;
      s_q.avg_h5 <= ofhd_pkg::RST_AVG_H5;
      s_q.dis <= ofhd_pkg::RST_DISABLE;
      s_q.pdown <= {NOUT{1'b1}};
      for (int i = 0; i < NOUT; i++) begin
        s_q.hst[i] <= ofhd_pkg::OFHD_RUN;
      end
    end else begin
      s_q <= s_d;
    end
  end

  // Outputs all straight from flops
  assign rdata_o = s_q.rdata;
  assign out5_signal_format_o = s_q.fmt_ref[ofhd_pkg::FMT_LSB +: 3];
  assign freq_offset_ref_select_o =
    s_q.fmt_ref[ofhd_pkg::REF_LSB +: 3];
  assign holdover_average_time_o = s_q.avg_h5[ofhd_pkg::AVG_LSB +: 5];
  assign output_disable_o = s_q.pdown;
  assign out_held_o = s_q.held;
  assign held_level_o = s_q.lvl;

  // ****************************************************
  // Checks
  // ****************************************************
  sequence seq_sleep;
    sleep_i;
  endsequence

  chk_sleep_all_off: assert property (@(posedge ref_clk_i)
    disable iff (!rstn_i)
    seq_sleep |=> (&output_disable_o))
    else $error("sleep did not disable every output");
  chk_dis5_power: assert property (@(posedge ref_clk_i)
    disable iff (!rstn_i)
    s_q.dis[ofhd_pkg::DIS5_BIT] |=> output_disable_o[4])
    else $error("output five disable bit ignored");
  // Every set low disable bit must show, not only the all-ones pattern
  chk_dis_low_bits: assert property (@(posedge ref_clk_i)
    disable iff (!rstn_i)
    (s_q.dis[3:0] != 4'h0) |=> ((output_disable_o[3:0]
      & $past(s_q.dis[3:0])) == $past(s_q.dis[3:0])))
    else $error("outputs one to four not disabled");
  chk_fmt_reserved_ro: assert property (@(posedge ref_clk_i)
    disable iff (!rstn_i)
    s_q.fmt_ref[7:6] == 2'h0 && s_q.dis[7:6] == 2'h0 && !s_q.dis[4]
      && !s_q.avg_h5[2])
    else $error("reserved bit became set");
  chk_avg_reset: assert property (@(posedge ref_clk_i)
    !rstn_i |=> (s_q.avg_h5 == ofhd_pkg::RST_AVG_H5))
    else $error("averaging register reset value wrong");
  chk_hold_field_map: assert property (@(posedge ref_clk_i)
    disable iff (!rstn_i)
    (wr_en_i && addr_i == ofhd_pkg::ADDR_HOLD_14)
      |=> (hold_code[3] == $past(wdata_i[7:6])))
    else $error("output four hold field misplaced");
  chk_fmt_disable: assert property (@(posedge ref_clk_i)
    disable iff (!rstn_i)
    (out5_signal_format_o == ofhd_pkg::FMT_DISABLE) |=> output_disable_o[4])
    else $error("disable format left output five on");
  chk_ref_select: assert property (@(posedge ref_clk_i)
    disable iff (!rstn_i)
    (wr_en_i && addr_i == ofhd_pkg::ADDR_FMT_REF)
      |=> (freq_offset_ref_select_o == $past(wdata_i[2:0])))
    else $error("reference select not stored");

  // Per output: a hold only switches while the live clock sits at the held
  // level, and the held level never moves under a frozen output
  for (genvar g = 0; g < NOUT; g++) begin : g_chk
    sequence seq_held_steady;
      out_held_o[g] && $stable(out_held_o[g]);
    endsequence
    chk_hold_glitchless: assert property (@(posedge ref_clk_i)
      disable iff (!rstn_i)
      $changed(out_held_o[g]) |-> ($past(s_q.sync2[g]) == $past(s_q.lvl[g])))
      else $error("hold changed while clock not at held level");
    chk_held_level_steady: assert property (@(posedge ref_clk_i)
      disable iff (!rstn_i)
      seq_held_steady |-> $stable(held_level_o[g]))
      else $error("held level moved while output frozen");
  end
endmodule : ofhd_regs

// >>> common/ofhd_pkg.sv
/*
  Constants for the output format, static hold and disable register bank.
  Assumes a byte-wide register port from the serial control port decoder.
*/
package ofhd_pkg;
  localparam int unsigned NUM_OUT = 5;
  // ****************************************************
  // Register offsets
  // ****************************************************
  localparam logic [7:0] ADDR_FMT_REF = 8'h07;
  localparam logic [7:0] ADDR_HOLD_14 = 8'h08;
  localparam logic [7:0] ADDR_AVG_H5 = 8'h09;
  localparam logic [7:0] ADDR_DISABLE = 8'h0a;
  // ****************************************************
  // Reset values and writable masks
  // ****************************************************
  localparam logic [7:0] RST_FMT_REF = 8'h00;
  localparam logic [7:0] RST_HOLD_14 = 8'h00;
  localparam logic [7:0] RST_AVG_H5 = 8'hc0;
  localparam logic [7:0] RST_DISABLE = 8'h00;
  localparam logic [7:0] WMASK_FMT_REF = 8'h3f;
  localparam logic [7:0] WMASK_HOLD_14 = 8'hff;
  localparam logic [7:0] WMASK_AVG_H5 = 8'hfb;
  localparam logic [7:0] WMASK_DISABLE = 8'h2f;
  // ****************************************************
  // Field positions
  // ****************************************************
  localparam int unsigned FMT_LSB = 3;
  localparam int unsigned AVG_LSB = 3;
  localparam int unsigned DIS5_BIT = 5;
  localparam int unsigned REF_LSB = 0;
  localparam int unsigned HOLD_W = 2;
  localparam int unsigned H5_LSB = 0;
  // ****************************************************
  // Codes
  // ****************************************************
  localparam logic [2:0] FMT_DISABLE = 3'h1;
  localparam logic [2:0] FMT_CMOS = 3'h2;
  localparam logic [2:0] FMT_LS_LVDS = 3'h3;
  localparam logic [2:0] FMT_LVPECL = 3'h5;
  localparam logic [2:0] FMT_CML = 3'h6;
  localparam logic [2:0] FMT_LVDS = 3'h7;
  localparam logic [2:0] REF_EXT = 3'h0;
  localparam logic [2:0] REF_MAX = 3'h4;
  localparam logic [1:0] HOLD_NORMAL = 2'h0;
  localparam logic [1:0] HOLD_LOW = 2'h1;
  localparam logic [1:0] HOLD_HIGH = 2'h2;
  typedef enum logic [1:0] {
    OFHD_RUN,
    OFHD_WAIT_LVL,
    OFHD_HELD
  } ofhd_hold_st_t;
endpackage : ofhd_pkg

// >>> tb/ofhd_host.sv
/*
  Host model of the serial port decoder side: byte writes and reads.
  Assumes ofhd_regs takes strobes on the rising edge of ref_clk_i.
*/
`timescale 1ns/1ps
module ofhd_host (
  input wire logic ref_clk_i,
  input wire logic [7:0] rdata_i,
  output logic wr_en_o = 1'b0,
  output logic rd_en_o = 1'b0,
  output logic [7:0] addr_o = 8'h00,
  output logic [7:0] wdata_o = 8'h00
);
  // ****************************************************
  // Bus cycles
  // ****************************************************
  // Released lines show the inverse so stale values never pass
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge ref_clk_i);
    wr_en_o <= 1'b1;
    addr_o <= a;
    wdata_o <= d;
    @(posedge ref_clk_i);
    wr_en_o <= 1'b0;
    addr_o <= ~a;
    wdata_o <= ~d;
  endtask : wr
  // Data is taken one edge after the read strobe is accepted
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge ref_clk_i);
    rd_en_o <= 1'b1;
    addr_o <= a;
    @(posedge ref_clk_i);
    rd_en_o <= 1'b0;
    addr_o <= ~a;
    @(posedge ref_clk_i);
    #1 d = rdata_i;
  endtask : rd
endmodule : ofhd_host

// >>> tb/ofhd_regs_tb_top.sv
/*
  Self-checking bench for ofhd_regs built from host register calls.
  Assumes ofhd_host drives the port; output clocks run free.
*/
`timescale 1ns/1ps
module ofhd_regs_tb_top;
  logic ref_clk_i = 1'b0;
  logic rstn_i = 1'b0;
  logic sleep_i = 1'b0;
  logic [4:0] clk_out_i = 5'h00;
  logic wr_en, rd_en;
  logic [7:0] addr, wdata, rdata, rd_v;
  logic [2:0] fmt_o, ref_o;
  logic [4:0] avg_o, dis_o, held_o, lvl_o;
  logic [2:0] fmts [6] = '{3'h1, 3'h2, 3'h3, 3'h5, 3'h6, 3'h7};
  int err_total = 0;
  int n_compared = 0;
  int cyc = 0;
  // ****************************************************
  // Clocks, timeout and instances
  // ****************************************************
  initial forever #10 ref_clk_i = ~ref_clk_i;
  // Odd step keeps output clocks out of phase with ref_clk_i
  always #7 clk_out_i <= clk_out_i + 5'h01;
  always @(posedge ref_clk_i) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      err_total++;
      close_out();
    end
  end
  ofhd_host host (.ref_clk_i(ref_clk_i), .rdata_i(rdata), .wr_en_o(wr_en),
    .rd_en_o(rd_en), .addr_o(addr), .wdata_o(wdata));
  ofhd_regs dut (.ref_clk_i(ref_clk_i), .rstn_i(rstn_i), .wr_en_i(wr_en),
    .rd_en_i(rd_en), .addr_i(addr), .wdata_i(wdata), .sleep_i(sleep_i),
    .clk_out_i(clk_out_i), .rdata_o(rdata), .out5_signal_format_o(fmt_o),
    .freq_offset_ref_select_o(ref_o), .holdover_average_time_o(avg_o),
    .output_disable_o(dis_o), .out_held_o(held_o), .held_level_o(lvl_o));
  // ****************************************************
  // Checking helpers
  // ****************************************************
  task automatic chk(input string n, input logic [7:0] s, e);
    n_compared++;
    if (s !== e) begin
      err_total++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, s);
    end
  endtask : chk
  task automatic chk_rd(input string n, input logic [7:0] a, e);
    host.rd(a, rd_v);
    chk(n, rd_v, e);
  endtask : chk_rd
  // Bounded wait: hold needs the synced clock to reach the level
  task automatic wait_held(input logic [4:0] e);
    for (int k = 0; k < 100 && held_o !== e; k++) begin
      @(posedge ref_clk_i);
      #1;
    end
    chk("held", {3'h0, held_o}, {3'h0, e});
  endtask : wait_held
  task automatic close_out();
    if (err_total == 0 && n_compared > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : close_out
  // ****************************************************
  // Tests
  // ****************************************************
  initial begin
    repeat (20) @(posedge ref_clk_i);
    rstn_i <= 1'b1;
    chk_rd("fmt_ref", 8'h07, 8'h00);
    chk_rd("hold_14", 8'h08, 8'h00);
    chk_rd("avg_h5", 8'h09, 8'hc0);
    chk_rd("unmapped", 8'h20, 8'h00);
    // A write next to the bank must not alias into it
    host.wr(8'h0b, 8'hff);
    chk_rd("disable", 8'h0a, 8'h00);
    // Legal codes only, so other outputs never exceed the power mix
    for (int i = 0; i < 6; i++) begin
      host.wr(8'h07, {2'h3, fmts[i], 3'(i % 5)});
      chk_rd("fmt_rd", 8'h07, {2'h0, fmts[i], 3'(i % 5)});
      chk("format", {5'h0, fmt_o}, {5'h0, fmts[i]});
      chk("ref_sel", {5'h0, ref_o}, {5'h0, 3'(i % 5)});
      chk("dis5", {7'h0, dis_o[4]}, {7'h0, fmts[i] == 3'h1});
    end
    host.wr(8'h0a, 8'hff);
    chk_rd("dis_rd", 8'h0a, 8'h2f);
    chk("dis_all", {3'h0, dis_o}, 8'h1f);
    host.wr(8'h0a, 8'h24);
    chk_rd("dis_rd2", 8'h0a, 8'h24);
    chk("dis_35", {3'h0, dis_o}, 8'h14);
    // Sleep overrides every disable bit and format code
    @(posedge ref_clk_i) sleep_i <= 1'b1;
    repeat (3) @(posedge ref_clk_i);
    #1 chk("sleep", {3'h0, dis_o}, 8'h1f);
    @(posedge ref_clk_i) sleep_i <= 1'b0;
    host.wr(8'h0a, 8'h00);
    host.wr(8'h09, 8'hc6);
    chk_rd("avg_rd", 8'h09, 8'hc2);
    chk("avg", {3'h0, avg_o}, 8'h18);
    host.wr(8'h08, 8'h99);
    wait_held(5'h1f);
    chk("level", {3'h0, lvl_o}, 8'h1a);
    // Swap every level of outputs one to four while they are frozen
    host.wr(8'h08, 8'h66);
    for (int k = 0; k < 100 && lvl_o !== 5'h15; k++) begin
      @(posedge ref_clk_i);
      #1;
    end
    wait_held(5'h1f);
    chk("level_swap", {3'h0, lvl_o}, 8'h15);
    host.wr(8'h08, 8'h00);
    host.wr(8'h09, 8'hc0);
    wait_held(5'h00);
    close_out();
  end
endmodule : ofhd_regs_tb_top
